// ===== rtl/chp_pkg.sv
// Shared constants and types of the codec host transfer port
package chp_pkg;
  // Clock and sample timing
  localparam int unsigned CLK_HZ     = 25_000_000;
  localparam int unsigned SAMPLE_HZ  = 48_000;
  localparam int unsigned SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
  // Capture request point as a fraction of the sample period
  localparam int unsigned CAP_NUM    = 3;
  localparam int unsigned CAP_DEN    = 4;
  // Data path
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [1:0]  DATA_ADDR  = 2'h3;
  // Reset values
  localparam logic [14:0] PIN_IDLE   = 15'h7c00;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [1:0]  EXT_RST    = 2'h0;
  localparam logic [7:0]  BUS_RST    = 8'h00;
  // Playback drain sequencer
  typedef enum {dr_idle, dr_pop} chp_drain_e;
endpackage : chp_pkg

// ===== rtl/chp_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/10ps

module chp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst_b,
  // Fill side
  input  wire logic                          in_valid,
  output logic                               in_ready,
  input  wire logic [WIDTH-1:0]              in_data,
  // Drain side
  output logic                               out_valid,
  input  wire logic                          out_ready,
  output logic [WIDTH-1:0]                   out_data,
  // Occupancy
  output logic [$clog2(DEPTH+1)-1:0]         level
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("chp_fifo: DEPTH below 2 or WIDTH below 1");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wp_ff;
  logic [AW-1:0]    rp_ff;
  logic [CW-1:0]    cnt_ff;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (32'(p) == DEPTH - 1) ? '0 : p + 1'b1;
  endfunction : ptr_inc

  assign in_ready  = cnt_ff != CW'(DEPTH);
  assign out_valid = cnt_ff != '0;
  assign out_data  = mem_ff[rp_ff];
  assign level     = cnt_ff;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wp_ff <= ptr_inc(wp_ff);
      end
      if (pop) begin
        rp_ff <= ptr_inc(rp_ff);
      end
      cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
    end
  end
endmodule : chp_fifo

// ===== rtl/chp_port.sv
// Codec host transfer port: byte bus, PIO, DMA handshakes, sample count
`timescale 1ns/10ps

module chp_port #(
  parameter int unsigned SAMPLE_CYCLES = chp_pkg::SAMPLE_CYC,
  parameter int unsigned FIFO_DEPTH    = chp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Host bus pins
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [1:0]  host_addr_in,
  input  wire logic [7:0]  host_byte_bus_i,
  output logic [7:0]       host_byte_bus_o,
  output logic             host_byte_bus_oe_n,
  input  wire logic        play_dma_ack_n,
  input  wire logic        capture_dma_ack_n,
  output logic             play_dma_request,
  output logic             capture_dma_request,
  output logic             irq_pin,
  output logic [1:0]       ext_out_bits,
  // Configuration bits
  input  wire logic        play_run,
  input  wire logic        capture_run,
  input  wire logic        play_programmed_sel,
  input  wire logic        capture_programmed_sel,
  input  wire logic        one_channel_dma,
  input  wire logic        request_hold_on_irq,
  input  wire logic        irq_pin_gate,
  input  wire logic        fmt_stereo,
  input  wire logic        fmt_16bit,
  input  wire logic [1:0]  ext_out_sel,
  input  wire logic [15:0] base_count,
  input  wire logic        base_upper_wr,
  input  wire logic        status_wr,
  // Status bits
  output logic             capture_ready_flag,
  output logic             play_ready_flag,
  output logic             irq_status,
  output logic             capture_overrun,
  output logic             play_underrun,
  // Register file access
  input  wire logic [7:0]  reg_rd_data,
  output logic             reg_wr_stb,
  output logic [1:0]       reg_addr,
  output logic [7:0]       reg_wr_data,
  // Converter side
  input  wire logic [15:0] cap_left,
  input  wire logic [15:0] cap_right,
  output logic [31:0]      play_sample,
  output logic             play_sample_stb
);
  localparam int unsigned CW = $clog2(FIFO_DEPTH + 1);
  localparam logic [15:0] PER_LAST = 16'(SAMPLE_CYCLES - 1);
  localparam logic [15:0] CAP_POINT =
    16'(SAMPLE_CYCLES * chp_pkg::CAP_NUM / chp_pkg::CAP_DEN);

  if (SAMPLE_CYCLES < 16 || SAMPLE_CYCLES > 65536 || FIFO_DEPTH < 4)
  begin : g_chk
    $error("chp_port: unsupported SAMPLE_CYCLES or FIFO_DEPTH");
  end

  ////////////////////////////////////////////////////////////////////////
  // Sample format helpers
  function automatic logic [2:0] sample_bytes(input logic st,
                                              input logic w16);
    sample_bytes = 3'h1 << (3'(st) + 3'(w16));
  endfunction : sample_bytes

  function automatic logic [7:0] pick_byte(input logic [31:0] buf_v,
                                           input logic [1:0]  idx,
                                           input logic        w16);
    if (w16) begin
      pick_byte = buf_v[8*idx +: 8];
    end else begin
      pick_byte = idx[0] ? buf_v[31:24] : buf_v[15:8];
    end
  endfunction : pick_byte

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and strobe edges
  logic [14:0] pin_s1_ff;
  logic [14:0] pin_s2_ff;
  logic [14:0] pin_s3_ff;
  logic        cs_s;
  logic        rd_s;
  logic        wr_s;
  logic        pak_s;
  logic        cak_s;
  logic [1:0]  adr_s;
  logic [7:0]  dat_s;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pin_s1_ff <= chp_pkg::PIN_IDLE;
      pin_s2_ff <= chp_pkg::PIN_IDLE;
      pin_s3_ff <= chp_pkg::PIN_IDLE;
    end else begin
      pin_s1_ff <= {cs_n, rd_n, wr_n, play_dma_ack_n, capture_dma_ack_n,
                    host_addr_in, host_byte_bus_i};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  assign {cs_s, rd_s, wr_s, pak_s, cak_s, adr_s, dat_s} = pin_s2_ff;

  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic wr_rise;
  assign rd_fall = pin_s3_ff[13] & ~rd_s;
  assign rd_rise = ~pin_s3_ff[13] & rd_s;
  assign wr_fall = pin_s3_ff[12] & ~wr_s;
  assign wr_rise = ~pin_s3_ff[12] & wr_s;

  ////////////////////////////////////////////////////////////////////////
  // Mode and cycle decode
  logic       cap_req_ff;
  logic       play_req_ff;
  logic       play_dma_en;
  logic       cap_dma_en;
  logic       play_pio;
  logic       cap_pio;
  logic       play_ack;
  logic       cap_ack;
  logic       reg_cyc;
  logic       pio_sel;
  logic       cap_rd;
  logic       play_wr;
  logic [2:0] nb;
  logic [1:0] last_idx;

  assign play_dma_en = play_run & ~play_programmed_sel;
  assign cap_dma_en  = capture_run & ~capture_programmed_sel
                     & ~(one_channel_dma & play_run);
  assign play_pio    = play_run & play_programmed_sel;
  assign cap_pio     = capture_run & capture_programmed_sel;
  assign play_ack    = ~pak_s & ~(one_channel_dma & cap_req_ff);
  assign cap_ack     = one_channel_dma ? (~pak_s & cap_req_ff)
                                       : ~cak_s;
  assign reg_cyc     = ~cs_s & pak_s
                     & (cak_s | one_channel_dma);
  assign pio_sel     = reg_cyc & (adr_s == chp_pkg::DATA_ADDR);
  assign cap_rd      = cap_ack | (pio_sel & cap_pio);
  assign play_wr     = play_ack | (pio_sel & play_pio);
  assign nb          = sample_bytes(fmt_stereo, fmt_16bit);
  assign last_idx    = 2'(nb - 3'h1);

  ////////////////////////////////////////////////////////////////////////
  // Sample period timer
  logic [15:0] per_ff;
  logic        tick_start;
  logic        tick_cap;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      per_ff <= '0;
    end else begin
      per_ff <= (per_ff == PER_LAST) ? '0 : per_ff + 16'h0001;
    end
  end

  assign tick_start = per_ff == 16'h0000;
  assign tick_cap   = per_ff == CAP_POINT;

  ////////////////////////////////////////////////////////////////////////
  // Playback FIFO and drain sequencer
  logic [CW-1:0]      fifo_lvl;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic [7:0]         fifo_out_data;
  logic               fifo_push;
  logic               drain_pop;
  logic               room_ok;
  logic               wr_play_ff;
  logic               wr_reg_ff;
  logic [1:0]         play_idx_ff;
  chp_pkg::chp_drain_e drain_ff;
  logic [1:0]         drain_cnt_ff;
  logic [31:0]        asm_ff;
  logic               stb_ff;
  logic               underrun_ff;

  assign room_ok   = (int'(fifo_lvl) + int'(nb)) <= int'(FIFO_DEPTH);
  assign fifo_push = wr_rise & wr_play_ff;
  assign drain_pop = (drain_ff == chp_pkg::dr_pop) & fifo_out_valid;

  chp_fifo #(
    .WIDTH (chp_pkg::BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (dat_s),
    .out_valid (fifo_out_valid),
    .out_ready (drain_ff == chp_pkg::dr_pop),
    .out_data  (fifo_out_data),
    .level     (fifo_lvl)
  );

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      drain_ff     <= chp_pkg::dr_idle;
      drain_cnt_ff <= '0;
      asm_ff       <= '0;
      stb_ff       <= 1'b0;
      underrun_ff  <= 1'b0;
    end else begin
      stb_ff <= 1'b0;
      case (drain_ff)
        chp_pkg::dr_idle: begin
          if (tick_start && play_run) begin
            underrun_ff <= int'(fifo_lvl) < int'(nb);
            if (int'(fifo_lvl) >= int'(nb)) begin
              drain_ff     <= chp_pkg::dr_pop;
              drain_cnt_ff <= '0;
            end
          end
        end
        chp_pkg::dr_pop: begin
          if (drain_pop) begin
            asm_ff       <= {fifo_out_data, asm_ff[31:8]};
            drain_cnt_ff <= drain_cnt_ff + 2'h1;
            if (drain_cnt_ff == last_idx) begin
              drain_ff <= chp_pkg::dr_idle;
              stb_ff   <= 1'b1;
            end
          end
        end
        default: drain_ff <= chp_pkg::dr_idle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write cycles: playback data and register writes
  logic       play_rdy_ff;
  logic       reg_stb_ff;
  logic [1:0] reg_adr_ff;
  logic [7:0] reg_dat_ff;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wr_play_ff  <= 1'b0;
      wr_reg_ff   <= 1'b0;
      play_idx_ff <= '0;
      reg_stb_ff  <= 1'b0;
      reg_adr_ff  <= '0;
      reg_dat_ff  <= chp_pkg::BUS_RST;
    end else begin
      reg_stb_ff <= 1'b0;
      if (wr_fall) begin
        wr_play_ff <= play_wr;
        wr_reg_ff  <= reg_cyc & ~(pio_sel & play_pio);
      end
      if (wr_rise && wr_play_ff && fifo_in_ready) begin
        play_idx_ff <= (play_idx_ff == last_idx) ? '0
                                                 : play_idx_ff + 2'h1;
      end
      if (wr_rise && wr_reg_ff) begin
        reg_stb_ff <= 1'b1;
        reg_adr_ff <= adr_s;
        reg_dat_ff <= dat_s;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      play_req_ff <= 1'b0;
      play_rdy_ff <= 1'b0;
    end else begin
      if (tick_start && play_dma_en && room_ok) begin
        play_req_ff <= 1'b1;
      end else if (wr_fall && play_ack && play_idx_ff == last_idx) begin
        play_req_ff <= 1'b0;
      end
      if (tick_start && play_pio && room_ok) begin
        play_rdy_ff <= 1'b1;
      end else if (wr_fall && pio_sel && play_pio && play_idx_ff == last_idx) begin
        play_rdy_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read cycles: capture data and register reads
  logic [31:0] cap_buf_ff;
  logic [1:0]  cap_idx_ff;
  logic        cap_rdy_ff;
  logic        rd_cap_ff;
  logic        overrun_ff;
  logic [7:0]  bus_ff;
  logic        oe_n_ff;
  logic        cap_pend;

  assign cap_pend = cap_req_ff | cap_rdy_ff | (cap_idx_ff != 2'h0);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      bus_ff     <= chp_pkg::BUS_RST;
      oe_n_ff    <= 1'b1;
      rd_cap_ff  <= 1'b0;
      cap_idx_ff <= '0;
    end else begin
      if (rd_fall && (cap_rd || reg_cyc)) begin
        rd_cap_ff <= cap_rd;
        oe_n_ff   <= 1'b0;
        bus_ff    <= cap_rd ? pick_byte(cap_buf_ff, cap_idx_ff, fmt_16bit)
                            : reg_rd_data;
      end else if (rd_rise) begin
        oe_n_ff   <= 1'b1;
        rd_cap_ff <= 1'b0;
        if (rd_cap_ff) begin
          cap_idx_ff <= (cap_idx_ff == last_idx) ? '0
                                                 : cap_idx_ff + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cap_buf_ff <= '0;
      cap_req_ff <= 1'b0;
      cap_rdy_ff <= 1'b0;
      overrun_ff <= 1'b0;
    end else begin
      if (tick_cap && capture_run) begin
        overrun_ff <= cap_pend;
        if (!cap_pend) begin
          cap_buf_ff <= {cap_right, cap_left};
        end
      end
      if (rd_fall && cap_ack && cap_idx_ff == last_idx) begin
        cap_req_ff <= 1'b0;
      end else if (tick_cap && cap_dma_en && !cap_pend) begin
        cap_req_ff <= 1'b1;
      end
      if (rd_fall && pio_sel && cap_pio && cap_idx_ff == last_idx) begin
        cap_rdy_ff <= 1'b0;
      end else if (tick_cap && cap_pio && !cap_pend) begin
        cap_rdy_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request pins, control outputs and sample counter
  logic        play_pin_ff;
  logic        cap_pin_ff;
  logic [1:0]  ext_ff;
  logic [15:0] cur_ff;
  logic        irq_st_ff;
  logic        irq_pin_ff;
  logic        cnt_en;
  logic        cnt_uf;

  assign cnt_en = tick_start & (play_run | capture_run)
                & (~request_hold_on_irq | ~irq_st_ff);
  assign cnt_uf = cnt_en & (cur_ff == 16'h0000) & ~base_upper_wr;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      play_pin_ff <= 1'b0;
      cap_pin_ff  <= 1'b0;
      ext_ff      <= chp_pkg::EXT_RST;
    end else begin
      play_pin_ff <= play_req_ff
                   | (one_channel_dma & cap_req_ff);
      cap_pin_ff  <= cap_req_ff & ~one_channel_dma;
      if (tick_start) begin
        ext_ff <= ext_out_sel;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cur_ff     <= chp_pkg::COUNT_RST;
      irq_st_ff  <= 1'b0;
      irq_pin_ff <= 1'b0;
    end else begin
      if (base_upper_wr) begin
        cur_ff <= base_count;
      end else if (cnt_uf) begin
        cur_ff <= base_count;
      end else if (cnt_en) begin
        cur_ff <= cur_ff - 16'h0001;
      end
      if (cnt_uf) begin
        irq_st_ff <= 1'b1;
      end else if (status_wr) begin
        irq_st_ff <= 1'b0;
      end
      irq_pin_ff <= (cnt_uf | (irq_st_ff & ~status_wr))
                  & irq_pin_gate;
    end
  end

  assign host_byte_bus_o     = bus_ff;
  assign host_byte_bus_oe_n  = oe_n_ff;
  assign play_dma_request    = play_pin_ff;
  assign capture_dma_request = cap_pin_ff;
  assign irq_pin             = irq_pin_ff;
  assign ext_out_bits        = ext_ff;
  assign capture_ready_flag  = cap_rdy_ff;
  assign play_ready_flag     = play_rdy_ff;
  assign irq_status          = irq_st_ff;
  assign capture_overrun     = overrun_ff;
  assign play_underrun       = underrun_ff;
  assign reg_wr_stb          = reg_stb_ff;
  assign reg_addr            = reg_adr_ff;
  assign reg_wr_data         = reg_dat_ff;
  assign play_sample         = asm_ff;
  assign play_sample_stb     = stb_ff;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_play_req_early;
    @(posedge mclk) disable iff (!rst_b)
    $rose(play_req_ff) |-> $past(per_ff) == 16'h0000;
  endproperty
  a_play_req_early: assert property (p_play_req_early)
    else $error("play request raised away from period start");

  property p_cap_req_late;
    @(posedge mclk) disable iff (!rst_b)
    $rose(cap_req_ff) |-> $past(per_ff) == CAP_POINT;
  endproperty
  a_cap_req_late: assert property (p_cap_req_late)
    else $error("capture request raised away from capture point");

  property p_one_chan_quiet;
    @(posedge mclk) disable iff (!rst_b)
    one_channel_dma && $past(one_channel_dma) |-> !capture_dma_request;
  endproperty
  a_one_chan_quiet: assert property (p_one_chan_quiet)
    else $error("capture request pin high in one-channel mode");

  property p_reg_no_dma;
    @(posedge mclk) disable iff (!rst_b)
    reg_wr_stb |-> $past(!play_ack && !cap_ack && !cs_s);
  endproperty
  a_reg_no_dma: assert property (p_reg_no_dma)
    else $error("register write during DMA acknowledge");

  property p_read_drive;
    @(posedge mclk) disable iff (!rst_b)
    rd_fall && reg_cyc ##1 !rd_s [*2] |-> !host_byte_bus_oe_n [*2];
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("bus not driven while read strobe low");

  property p_irq_gated;
    @(posedge mclk) disable iff (!rst_b)
    !irq_pin_gate && $past(!irq_pin_gate) |-> !irq_pin;
  endproperty
  a_irq_gated: assert property (p_irq_gated)
    else $error("interrupt pin high with gate clear");

  property p_underflow_reload;
    @(posedge mclk) disable iff (!rst_b)
    cnt_uf |=> irq_status && cur_ff == $past(base_count);
  endproperty
  a_underflow_reload: assert property (p_underflow_reload)
    else $error("underflow did not set status and reload");

  property p_status_clear;
    @(posedge mclk) disable iff (!rst_b)
    status_wr && !cnt_uf |=> !irq_status ##0 !irq_pin;
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status write did not clear interrupt");

  property p_ext_follow;
    @(posedge mclk) disable iff (!rst_b)
    tick_start |=> ext_out_bits == $past(ext_out_sel);
  endproperty
  a_ext_follow: assert property (p_ext_follow)
    else $error("output pins not updated at period start");
endmodule : chp_port

// ===== testbench/chp_host.sv
// Host bus model: register cycles and DMA acknowledge cycles
`timescale 1ns/10ps
module chp_host (
  // Clock
  input  wire logic       mclk,
  // Strobes, address, acknowledges
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic [1:0]      adr,
  output logic            pak,
  output logic            cak,
  // Byte bus
  input  wire logic [7:0] bo,
  input  wire logic       oe_n,
  output logic [7:0]      bi
);
  logic       drv = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [7:0] last = 8'h00;
  // A released bus shows the inverse of its last value
  assign bi = !oe_n ? bo : drv ? wd : ~last;
  always @(posedge mclk) if (!oe_n || drv) last <= bi;
  initial {cs_n, rd_n, wr_n, pak, cak, adr} = 7'h7c;
  // Kind 0 register cycle, 1 playback ack, 2 capture ack
  task automatic xfer(input int k, input logic w, input logic [1:0] a,
                      input logic [7:0] d, output logic [7:0] r);
    @(negedge mclk);
    cs_n = k != 0;
    pak = k != 1;
    cak = k != 2;
    adr = a;
    wd = d;
    drv = w;
    @(negedge mclk);
    rd_n = w;
    wr_n = !w;
    repeat (6) @(negedge mclk);
    r = bi;
    {rd_n, wr_n} = 2'h3;
    repeat (4) @(negedge mclk);
    drv = 1'b0;
    {cs_n, pak, cak} = 3'h7;
  endtask : xfer
endmodule : chp_host

// ===== testbench/chp_port_tb.sv
// Self-checking bench for the codec host transfer port
`timescale 1ns/10ps
module chp_port_tb;
  logic mclk, rst_b, play_run, capture_run, play_programmed_sel;
  logic capture_programmed_sel, one_channel_dma, request_hold_on_irq;
  logic irq_pin_gate, fmt_stereo, fmt_16bit, base_upper_wr, status_wr;
  logic cs_n, rd_n, wr_n, pak, cak, oe_n, play_dma_request, irq_pin;
  logic capture_dma_request, capture_ready_flag, irq_status, reg_wr_stb;
  logic        play_sample_stb, play_ready_flag;
  logic        capture_overrun, play_underrun;
  logic        got = 1'b0;
  logic [1:0]  ext_out_sel, adr, ext_out_bits, reg_addr;
  logic [7:0]  reg_rd_data, bi, bo, q, reg_wr_data;
  logic [9:0]  wlog;
  logic [15:0] base_count, cap_left, cap_right;
  logic [31:0] play_sample, ps;
  int          fails = 0, check_count = 0, i;
  chp_port #(.SAMPLE_CYCLES(128)) dut (.mclk, .rst_b, .cs_n, .rd_n, .wr_n,
    .host_addr_in(adr), .host_byte_bus_i(bi), .host_byte_bus_o(bo),
    .host_byte_bus_oe_n(oe_n), .play_dma_ack_n(pak),
    .capture_dma_ack_n(cak), .play_dma_request, .capture_dma_request,
    .irq_pin, .ext_out_bits, .play_run, .capture_run, .play_programmed_sel,
    .capture_programmed_sel, .one_channel_dma, .request_hold_on_irq,
    .irq_pin_gate, .fmt_stereo, .fmt_16bit, .ext_out_sel, .base_count,
    .base_upper_wr, .status_wr, .capture_ready_flag, .play_ready_flag,
    .irq_status, .capture_overrun, .play_underrun, .reg_rd_data,
    .reg_wr_stb, .reg_addr, .reg_wr_data, .cap_left, .cap_right,
    .play_sample, .play_sample_stb);
  chp_host hst (.mclk, .cs_n, .rd_n, .wr_n, .adr, .pak, .cak, .bo, .oe_n,
    .bi);
  //////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : check
  task automatic wt(ref logic s);
    for (int n = 0; n < 400 && s !== 1'b1; n++) @(negedge mclk);
  endtask : wt
  task automatic rd(input int k, input logic [1:0] a, input logic [7:0] e);
    hst.xfer(k, 1'b0, a, 8'h00, q);
    check(q, e);
  endtask : rd
  task automatic wr(input int k, input logic [7:0] d);
    hst.xfer(k, 1'b1, 2'h0, d, q);
  endtask : wr
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Record register writes and played samples
  always @(posedge mclk) begin
    if (reg_wr_stb === 1'b1) wlog <= {reg_addr, reg_wr_data};
    if (play_sample_stb === 1'b1) begin
      ps <= play_sample;
      got <= 1'b1;
    end
  end
  initial begin
    #400_000;
    fails++;
    give_verdict();
  end
  initial begin
    {rst_b, play_run, capture_run, play_programmed_sel} = 4'h0;
    {capture_programmed_sel, one_channel_dma, request_hold_on_irq} = 3'h0;
    {irq_pin_gate, fmt_stereo, fmt_16bit, base_upper_wr, status_wr} = 5'h0;
    {ext_out_sel, reg_rd_data, base_count} = 26'h2;
    {cap_left, cap_right} = 32'hb7a193c4;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    @(negedge mclk);
    check({oe_n, bo, play_dma_request, capture_dma_request, irq_pin,
           ext_out_bits}, 14'h2000);
    ext_out_sel = 2'h2;
    reg_rd_data = 8'h5a;
    rd(0, 2'h1, 8'h5a);
    wr(0, 8'ha5);
    repeat (3) @(negedge mclk);
    check(wlog, 10'h0a5);
    {fmt_stereo, fmt_16bit, capture_run} = 3'h7;
    wt(capture_dma_request);
    check(capture_dma_request, 1'b1);
    rd(2, 2'h3, cap_left[7:0]);
    rd(2, 2'h0, cap_left[15:8]);
    capture_run = 1'b0;
    rd(2, 2'h0, cap_right[7:0]);
    check(capture_dma_request, 1'b1);
    rd(2, 2'h0, cap_right[15:8]);
    check(capture_dma_request, 1'b0);
    play_run = 1'b1;
    wt(play_dma_request);
    check(play_underrun, 1'b1);
    for (i = 0; i < 4; i++) wr(1, 8'(8'h11 * (i + 1)));
    check(play_dma_request, 1'b0);
    wt(got);
    check(ps, 32'h44332211);
    check(play_underrun, 1'b0);
    play_run = 1'b0;
    repeat (4) @(negedge mclk);
    if (play_dma_request === 1'b1)
      for (i = 0; i < 4; i++) wr(1, 8'h00);
    check(play_dma_request, 1'b0);
    check({wlog, ext_out_bits}, 12'h296);
    {fmt_stereo, fmt_16bit, one_channel_dma, capture_run} = 4'h3;
    wt(play_dma_request);
    check(capture_dma_request, 1'b0);
    rd(1, 2'h0, cap_left[15:8]);
    capture_run = 1'b0;
    check(play_dma_request, 1'b0);
    {one_channel_dma, capture_programmed_sel, capture_run} = 3'h3;
    {irq_pin_gate, base_upper_wr, status_wr} = 3'h7;
    @(negedge mclk);
    {base_upper_wr, status_wr} = 2'h0;
    repeat (200) @(negedge mclk);
    check(irq_status, 1'b0);
    wt(capture_ready_flag);
    check(capture_dma_request, 1'b0);
    rd(0, 2'h3, cap_left[15:8]);
    wt(irq_status);
    check({irq_status, irq_pin}, 2'h3);
    status_wr = 1'b1;
    @(negedge mclk);
    status_wr = 1'b0;
    repeat (2) @(negedge mclk);
    check({irq_status, irq_pin}, 2'h0);
    {play_run, play_programmed_sel} = 2'h3;
    rd(0, 2'h3, cap_left[15:8]);
    wt(capture_ready_flag);
    check({capture_overrun, play_ready_flag}, 2'h0);
    wt(play_ready_flag);
    check(play_ready_flag, 1'b1);
    hst.xfer(0, 1'b1, 2'h3, 8'h3c, q);
    check(play_ready_flag, 1'b0);
    give_verdict();
  end
endmodule : chp_port_tb
